// ### hw/lcd_instruction_decoder.sv
// instruction and data decoder of a character display controller
//
// Summary of operation
// - Reset: display off, display ram selected, cursor and shift zero.
// - Select high write: character byte stored at display address.
// - Function set: bit4 picks 8-bit transfers, bit3 picks two lines.
// - Display control: bit2 turns display on, bit1 shows cursor.
// - Entry mode: bit1 increments address per write, cursor moves right.
// - Entry mode bit0: every later character write shifts the display.
// - Shift on write with increment moves picture left, lines together.
// - Shift instruction with bits 3,2 clear moves only cursor left.
// - Shift instruction bits 3,2 set: display and cursor move right.
// - Shift instruction bit3 clear, bit2 set moves only cursor right.
// - Return home clears display shift and puts cursor at address zero.
// - Bit7 instruction loads display address; 0x40 is second line start.
// - Write after cursor move overwrites there, then shifts display.
`timescale 1ns/1ns
`include "lcdid_consts.svh"

module lcd_instruction_decoder #(
    parameter int EXEC_CYC = `LCDID_EXEC_CYC,
    parameter int HOME_CYC = `LCDID_HOME_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    // host parallel port pins
    input wire logic instrDataSelect,
    input wire logic readNotWrite,
    input wire logic busStrobe,
    input wire logic [7:0] busData,
    // row and column scan side
    input wire logic [6:0] scanAddr,
    output logic [7:0] scanChar,
    // mode and position state
    output lcdid_pkg::lcdid_mode_type mode,
    output logic [6:0] cursorAddr,
    output logic [6:0] displayShift,
    output logic glyphSelect,
    output logic [5:0] glyphAddr,
    // glyph pattern write strobe
    output logic glyphWrite,
    output logic [7:0] glyphData,
    // execution in progress
    output logic busy
);

    lcdid_pkg::lcdid_bus_type busWord;
    logic busEvent;
    lcdid_pkg::lcdid_state_type state_reg;
    lcdid_pkg::lcdid_state_type state_next;
    logic [`LCDID_CNT_W-1:0] count_reg;
    lcdid_pkg::lcdid_cmd_type cmd;
    logic accept;
    logic isInstr;
    logic isData;
    logic charWrite;
    logic [7:0] d;

    lcdid_pin_sync u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .instrDataSelect(instrDataSelect),
        .readNotWrite(readNotWrite),
        .busStrobe(busStrobe),
        .busData(busData),
        .busWord(busWord),
        .busEvent(busEvent)
    );

    // transfers during execution are dropped; host must wait
    assign accept = busEvent && (state_reg == lcdid_pkg::ST_IDLE);
    assign isInstr = accept && !busWord.sel && !busWord.rnw;
    assign isData = accept && busWord.sel && !busWord.rnw;
    assign charWrite = isData && !glyphSelect;
    assign d = busWord.data;
    assign cmd = lcdid_pkg::lcdid_classify(d);
    assign busy = (state_reg == lcdid_pkg::ST_EXEC);

    lcdid_char_ram u_ram (
        .mclk(mclk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .wrEn(charWrite),
        .wrAddr(cursorAddr),
        .wrData(d),
        .rdAddr(scanAddr),
        .rdData(scanChar)
    );

    // busy sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lcdid_pkg::ST_IDLE: begin
                if (isInstr || isData) state_next = lcdid_pkg::ST_EXEC;
            end
            lcdid_pkg::ST_EXEC: begin
                if (count_reg <= `LCDID_CNT_W'(1)) begin
                    state_next = lcdid_pkg::ST_IDLE;
                end
            end
            default: state_next = lcdid_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= lcdid_pkg::ST_IDLE;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    // execution time counter; return home takes longer
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else if (clkEn) begin
            if (isInstr && cmd == lcdid_pkg::CMD_HOME) begin
                count_reg <= `LCDID_CNT_W'(HOME_CYC);
            end else if (isInstr || isData) begin
                count_reg <= `LCDID_CNT_W'(EXEC_CYC);
            end else if (count_reg != '0) begin
                count_reg <= count_reg - `LCDID_CNT_W'(1);
            end
        end
    end

    // mode bits from function set, display control and entry mode
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= `LCDID_MODE_RST;
        end else if (clkEn && isInstr) begin
            unique case (cmd)
                lcdid_pkg::CMD_FUNC: begin
                    mode.eightBit <= d[`LCDID_B_DL];
                    mode.twoLine <= d[`LCDID_B_LINES];
                end
                lcdid_pkg::CMD_DISP: begin
                    mode.displayOn <= d[`LCDID_B_DISP];
                    mode.cursorOn <= d[`LCDID_B_CURS];
                    mode.blinkOn <= d[`LCDID_B_BLINK];
                end
                lcdid_pkg::CMD_ENTRY: begin
                    mode.incr <= d[`LCDID_B_INCR];
                    mode.shiftOnWrite <= d[`LCDID_B_SHIFT];
                end
                lcdid_pkg::CMD_NONE, lcdid_pkg::CMD_CLEAR,
                lcdid_pkg::CMD_HOME, lcdid_pkg::CMD_SHIFT,
                lcdid_pkg::CMD_GLYPH, lcdid_pkg::CMD_DDADDR: begin
                end
            endcase
        end
    end

    // data writes go to display ram until a glyph address is set
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            glyphSelect <= 1'b0;
        end else if (clkEn && isInstr) begin
            if (cmd == lcdid_pkg::CMD_DDADDR ||
                cmd == lcdid_pkg::CMD_HOME) begin
                glyphSelect <= 1'b0;
            end else if (cmd == lcdid_pkg::CMD_GLYPH) begin
                glyphSelect <= 1'b1;
            end
        end
    end

    // cursor position in display ram
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cursorAddr <= `LCDID_ADDR_ZERO;
        end else if (clkEn) begin
            if (charWrite) begin
                // store first, then step by the entry direction
                cursorAddr <= lcdid_pkg::lcdid_step(cursorAddr, mode.incr,
                                                    mode.twoLine);
            end else if (isInstr && cmd == lcdid_pkg::CMD_DDADDR) begin
                cursorAddr <= d[6:0];
            end else if (isInstr && cmd == lcdid_pkg::CMD_HOME) begin
                cursorAddr <= `LCDID_ADDR_ZERO;
            end else if (isInstr && cmd == lcdid_pkg::CMD_SHIFT) begin
                // bit2 gives direction: clear left, set right
                cursorAddr <= lcdid_pkg::lcdid_step(
                    cursorAddr, d[`LCDID_B_RL], mode.twoLine);
            end
        end
    end

    // display offset; grows as the picture moves left
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            displayShift <= 7'h00;
        end else if (clkEn) begin
            if (charWrite && mode.shiftOnWrite) begin
                // increment shifts left, decrement right
                displayShift <= lcdid_pkg::lcdid_shift(
                    displayShift, mode.incr, mode.twoLine);
            end else if (isInstr && cmd == lcdid_pkg::CMD_HOME) begin
                displayShift <= 7'h00;
            end else if (isInstr && cmd == lcdid_pkg::CMD_SHIFT &&
                         d[`LCDID_B_SC]) begin
                // display shift: right shrinks offset, left grows it
                displayShift <= lcdid_pkg::lcdid_shift(
                    displayShift, !d[`LCDID_B_RL], mode.twoLine);
            end
        end
    end

    // glyph ram address and write strobe; pattern layout lives elsewhere
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            glyphAddr <= `LCDID_GLYPH_ZERO;
            glyphWrite <= 1'b0;
            glyphData <= 8'h00;
        end else if (clkEn) begin
            glyphWrite <= isData && glyphSelect;
            if (isData && glyphSelect) begin
                glyphData <= d;
                glyphAddr <= mode.incr ? glyphAddr + 6'h01 : glyphAddr - 6'h01;
            end else if (isInstr && cmd == lcdid_pkg::CMD_GLYPH) begin
                glyphAddr <= d[5:0];
            end
        end else begin
            glyphWrite <= 1'b0;
        end
    end

endmodule

// ### inc/lcdid_consts.svh
// constants for the display instruction decoder
`ifndef LCDID_CONSTS_SVH
`define LCDID_CONSTS_SVH

// clock rate and execution times
`define LCDID_CLK_MHZ 20
`define LCDID_EXEC_NS 40000
`define LCDID_HOME_NS 1640000
`define LCDID_EXEC_CYC ((`LCDID_EXEC_NS * `LCDID_CLK_MHZ + 999) / 1000)
`define LCDID_HOME_CYC ((`LCDID_HOME_NS * `LCDID_CLK_MHZ + 999) / 1000)
`define LCDID_CNT_W 16

// display ram address map
`define LCDID_ADDR_W 7
`define LCDID_ADDR_ZERO 7'h00
`define LCDID_LINE2_BASE 7'h40
`define LCDID_LINE1_LAST 7'h27
`define LCDID_LINE2_LAST 7'h67
`define LCDID_ONE_LINE_LAST 7'h4f
`define LCDID_RAM_DEPTH 128

// display shift wraps at the line length
`define LCDID_SHIFT_LAST_2L 7'h27
`define LCDID_SHIFT_LAST_1L 7'h4f

// glyph ram address width
`define LCDID_GLYPH_W 6
`define LCDID_GLYPH_ZERO 6'h00

// instruction field positions
`define LCDID_B_DL 4
`define LCDID_B_LINES 3
`define LCDID_B_DISP 2
`define LCDID_B_CURS 1
`define LCDID_B_BLINK 0
`define LCDID_B_INCR 1
`define LCDID_B_SHIFT 0
`define LCDID_B_SC 3
`define LCDID_B_RL 2

// reset values: 8-bit, one line, display and cursor off, increment
`define LCDID_MODE_RST 7'h42
`define LCDID_SPACE_CHAR 8'h20

`endif

// ### inc/lcdid_pkg.sv
// types and shared arithmetic of the display instruction decoder
`include "lcdid_consts.svh"

package lcdid_pkg;

    // host pins after synchronisation
    typedef struct packed {
        logic sel;
        logic rnw;
        logic [7:0] data;
    } lcdid_bus_type;

    // mode bits set by instructions
    typedef struct packed {
        logic eightBit;
        logic twoLine;
        logic displayOn;
        logic cursorOn;
        logic blinkOn;
        logic incr;
        logic shiftOnWrite;
    } lcdid_mode_type;

    // instruction classes, highest set bit decides
    typedef enum logic [8:0] {
        CMD_NONE = 9'b000000001,
        CMD_CLEAR = 9'b000000010,
        CMD_HOME = 9'b000000100,
        CMD_ENTRY = 9'b000001000,
        CMD_DISP = 9'b000010000,
        CMD_SHIFT = 9'b000100000,
        CMD_FUNC = 9'b001000000,
        CMD_GLYPH = 9'b010000000,
        CMD_DDADDR = 9'b100000000
    } lcdid_cmd_type;

    // busy sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } lcdid_state_type;

    function automatic lcdid_cmd_type lcdid_classify(input logic [7:0] d);
        lcdid_cmd_type c;
        c = CMD_NONE;
        if (d[7]) c = CMD_DDADDR;
        else if (d[6]) c = CMD_GLYPH;
        else if (d[5]) c = CMD_FUNC;
        else if (d[4]) c = CMD_SHIFT;
        else if (d[3]) c = CMD_DISP;
        else if (d[2]) c = CMD_ENTRY;
        else if (d[1]) c = CMD_HOME;
        else if (d[0]) c = CMD_CLEAR;
        return c;
    endfunction

    // one step of the cursor address, wrapping line by line
    function automatic logic [6:0] lcdid_step(input logic [6:0] a,
                                              input logic up,
                                              input logic twoLine);
        logic [6:0] r;
        r = up ? a + 7'h01 : a - 7'h01;
        if (twoLine) begin
            if (up && a == `LCDID_LINE1_LAST) r = `LCDID_LINE2_BASE;
            if (up && a == `LCDID_LINE2_LAST) r = `LCDID_ADDR_ZERO;
            if (!up && a == `LCDID_ADDR_ZERO) r = `LCDID_LINE2_LAST;
            if (!up && a == `LCDID_LINE2_BASE) r = `LCDID_LINE1_LAST;
        end else begin
            if (up && a == `LCDID_ONE_LINE_LAST) r = `LCDID_ADDR_ZERO;
            if (!up && a == `LCDID_ADDR_ZERO) r = `LCDID_ONE_LINE_LAST;
        end
        return r;
    endfunction

    // display offset; up moves the picture left, both lines alike
    function automatic logic [6:0] lcdid_shift(input logic [6:0] s,
                                               input logic up,
                                               input logic twoLine);
        logic [6:0] last;
        logic [6:0] r;
        last = twoLine ? `LCDID_SHIFT_LAST_2L : `LCDID_SHIFT_LAST_1L;
        if (up) r = (s >= last) ? 7'h00 : s + 7'h01;
        else r = (s == 7'h00) ? last : s - 7'h01;
        return r;
    endfunction

endpackage

// ### hw/lcdid_pin_sync.sv
// two-stage synchroniser for the host port and strobe edge detect
`timescale 1ns/1ns

module lcdid_pin_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    // raw host pins
    input wire logic instrDataSelect,
    input wire logic readNotWrite,
    input wire logic busStrobe,
    input wire logic [7:0] busData,
    // synchronised transfer
    output lcdid_pkg::lcdid_bus_type busWord,
    output logic busEvent
);

    lcdid_pkg::lcdid_bus_type meta_reg;
    lcdid_pkg::lcdid_bus_type sync_reg;
    logic strobeMeta_reg;
    logic strobeSync_reg;
    logic strobeOld_reg;

    // first stage feeds only the second stage
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            strobeMeta_reg <= 1'b0;
            strobeSync_reg <= 1'b0;
            strobeOld_reg <= 1'b0;
        end else if (clkEn) begin
            meta_reg <= {instrDataSelect, readNotWrite, busData};
            sync_reg <= meta_reg;
            strobeMeta_reg <= busStrobe;
            strobeSync_reg <= strobeMeta_reg;
            strobeOld_reg <= strobeSync_reg;
        end
    end

    // hold the pins as seen while the strobe was high; hold time on the
    // host side may be shorter than a clock period
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busWord <= '0;
        end else if (clkEn && strobeSync_reg) begin
            busWord <= sync_reg;
        end
    end

    // transfer completes on the falling strobe edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busEvent <= 1'b0;
        end else if (clkEn) begin
            busEvent <= strobeOld_reg & ~strobeSync_reg;
        end else begin
            busEvent <= 1'b0;
        end
    end

endmodule

// ### hw/lcdid_char_ram.sv
// character display memory, one write port and a registered scan port
`timescale 1ns/1ns
`include "lcdid_consts.svh"

module lcdid_char_ram (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    // write port
    input wire logic wrEn,
    input wire logic [6:0] wrAddr,
    input wire logic [7:0] wrData,
    // scan read port
    input wire logic [6:0] rdAddr,
    output logic [7:0] rdData
);

    logic [7:0] mem [0:`LCDID_RAM_DEPTH-1];

    // contents are not reset; the display stays off until a display control instruction turns it on
    always_ff @(posedge mclk) begin
        if (clkEn && wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read data
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= `LCDID_SPACE_CHAR;
        end else if (clkEn) begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// ### testbench/lcdid_monitor.sv
// port assertions for the display instruction decoder
`timescale 1ns/1ns

module lcdid_monitor #(
    parameter int EXEC_CYC = 8,
    parameter int HOME_CYC = 16
) (
    // clock and reset
    input logic mclk,
    input logic reset_n,
    input logic clkEn,
    // host pins
    input logic instrDataSelect,
    input logic readNotWrite,
    input logic busStrobe,
    input logic [7:0] busData,
    // scan side
    input logic [6:0] scanAddr,
    input logic [7:0] scanChar,
    // state outputs
    input lcdid_pkg::lcdid_mode_type mode,
    input logic [6:0] cursorAddr,
    input logic [6:0] displayShift,
    input logic glyphSelect,
    input logic [5:0] glyphAddr,
    input logic glyphWrite,
    input logic [7:0] glyphData,
    input logic busy
);
    logic [15:0] busyLen_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // length of the busy run; saturates so a hang cannot wrap to zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busyLen_reg <= 16'h0000;
        end else if (!busy) begin
            busyLen_reg <= 16'h0000;
        end else if (busyLen_reg != 16'hffff) begin
            busyLen_reg <= busyLen_reg + 16'h0001;
        end
    end

    reset_state_a: assert property (
        !$past(reset_n) |-> mode == 7'h42 && cursorAddr == 7'h00
            && displayShift == 7'h00 && !glyphSelect)
        else $error("state not at reset values");
    glyph_select_a: assert property (
        $rose(glyphSelect) |-> $rose(busy))
        else $error("glyph target chosen without a transfer");
    cursor_update_a: assert property (
        !$stable(cursorAddr) |-> $rose(busy))
        else $error("cursor moved without a transfer");
    mode_update_a: assert property (
        !$stable(mode) |-> $rose(busy))
        else $error("mode changed without a transfer");
    shift_update_a: assert property (
        !$stable(displayShift) |-> $rose(busy))
        else $error("display shifted without a transfer");
    shift_step_a: assert property (
        $changed(displayShift) && displayShift != 7'h00
            && $past(displayShift) != 7'h00
        |-> (displayShift - $past(displayShift)) == 7'h01
            || ($past(displayShift) - displayShift) == 7'h01)
        else $error("display shift moved more than one place");
    busy_hold_a: assert property (
        $rose(busy) |=> busy [*2])
        else $error("busy dropped too early");
    busy_bound_a: assert property (
        busyLen_reg <= HOME_CYC + 2)
        else $error("busy held too long");
    glyph_write_a: assert property (
        glyphWrite |-> glyphSelect && $rose(busy))
        else $error("glyph write without a glyph transfer");

    cover property ($rose(busy));
    cover property ($changed(displayShift));
    cover property (cursorAddr == 7'h40);
    cover property (glyphWrite);
endmodule

bind lcd_instruction_decoder lcdid_monitor #(
    .EXEC_CYC(EXEC_CYC), .HOME_CYC(HOME_CYC)) lcdid_monitor_inst (
    .mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
    .instrDataSelect(instrDataSelect), .readNotWrite(readNotWrite),
    .busStrobe(busStrobe), .busData(busData), .scanAddr(scanAddr),
    .scanChar(scanChar), .mode(mode), .cursorAddr(cursorAddr),
    .displayShift(displayShift), .glyphSelect(glyphSelect),
    .glyphAddr(glyphAddr), .glyphWrite(glyphWrite),
    .glyphData(glyphData), .busy(busy));

// ### testbench/lcdid_host_model.sv
// host microcontroller model on the parallel port
`timescale 1ns/1ns

module lcdid_host_model (
    // clock and device status
    input wire logic mclk,
    input wire logic busy,
    // parallel port pins
    output logic instrDataSelect,
    output logic readNotWrite,
    output logic busStrobe,
    output logic [7:0] busData
);
    // write-only host, strobe idle low
    initial begin
        instrDataSelect = 1'b0;
        readNotWrite = 1'b0;
        busStrobe = 1'b0;
        busData = 8'h00;
    end

    // bounded wait for busy low, then the sync margin
    task automatic wait_idle(output bit ok);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        ok = (busy === 1'b0);
        repeat (3) @(posedge mclk);
    endtask

    // one write; ok only if busy went low before and rose after
    task automatic xfer(input logic sel, input logic [7:0] d,
                        output bit ok);
        int n;
        bit idle;
        wait_idle(idle);
        #1;
        instrDataSelect = sel;
        busData = d;
        busStrobe = 1'b1;
        repeat (4) @(posedge mclk);
        #1 busStrobe = 1'b0;
        repeat (3) @(posedge mclk);
        // hold over: inverse so stale data is never mistaken for valid
        #1 busData = ~d;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        ok = idle && (busy === 1'b1);
    endtask
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the display instruction decoder
`timescale 1ns/1ns

module tb_top;
    logic mclk, reset_n, clkEn, instrDataSelect, readNotWrite;
    logic busStrobe, glyphSelect, glyphWrite, busy;
    logic [7:0] busData, scanChar, glyphData;
    logic [6:0] scanAddr, cursorAddr, displayShift;
    logic [5:0] glyphAddr;
    lcdid_pkg::lcdid_mode_type mode;
    int fails;
    int checked;

    // short execution times keep the run brief
    lcd_instruction_decoder #(.EXEC_CYC(8), .HOME_CYC(16))
        lcd_instruction_decoder_inst (
        .mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
        .instrDataSelect(instrDataSelect), .readNotWrite(readNotWrite),
        .busStrobe(busStrobe), .busData(busData), .scanAddr(scanAddr),
        .scanChar(scanChar), .mode(mode), .cursorAddr(cursorAddr),
        .displayShift(displayShift), .glyphSelect(glyphSelect),
        .glyphAddr(glyphAddr), .glyphWrite(glyphWrite),
        .glyphData(glyphData), .busy(busy));

    lcdid_host_model lcdid_host_model_inst (
        .mclk(mclk), .busy(busy), .instrDataSelect(instrDataSelect),
        .readNotWrite(readNotWrite), .busStrobe(busStrobe),
        .busData(busData));

    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    task automatic test_done();
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_state(input logic [6:0] m, input logic [6:0] c,
                             input logic [6:0] s);
        checked++;
        if (mode !== m || cursorAddr !== c || displayShift !== s) begin
            fails++;
            $display("CHECK FAILED at %0t: mode %h cursor %h shift %h",
                     $time, mode, cursorAddr, displayShift);
        end
    endtask

    task automatic chk_glyph(input logic g, input logic [5:0] a,
                             input logic w, input logic [7:0] e);
        checked++;
        if (glyphSelect !== g || glyphAddr !== a || glyphWrite !== w ||
            glyphData !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: glyph %b %h %b %h", $time,
                     glyphSelect, glyphAddr, glyphWrite, glyphData);
        end
    endtask

    // scan port is registered, so allow two edges after the address
    task automatic chk_char(input logic [6:0] a, input logic [7:0] e);
        @(posedge mclk);
        #1 scanAddr = a;
        repeat (2) @(posedge mclk);
        #1;
        checked++;
        if (scanChar !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: char %h at %h", $time,
                     scanChar, a);
        end
    endtask

    // one transfer, then compare mode, cursor and shift at once
    task automatic step(input logic sel, input logic [7:0] d,
                        input logic [6:0] m, input logic [6:0] c,
                        input logic [6:0] s);
        bit ok;
        lcdid_host_model_inst.xfer(sel, d, ok);
        checked++;
        if (!ok) begin
            fails++;
            $display("CHECK FAILED at %0t: busy handshake lost", $time);
        end
        chk_state(m, c, s);
    endtask

    task automatic do_reset();
        @(posedge mclk);
        #1 reset_n = 1'b0;
        repeat (4) @(posedge mclk);
        #1 reset_n = 1'b1;
        chk_state(7'h42, 7'h00, 7'h00);
    endtask

    // two lines, display and cursor on, increment without shift
    task automatic t_setup();
        step(1'b0, 8'h38, 7'h62, 7'h00, 7'h00);
        step(1'b0, 8'h0e, 7'h7a, 7'h00, 7'h00);
        step(1'b0, 8'h06, 7'h7a, 7'h00, 7'h00);
    endtask

    // writes land in display memory with no target set first
    task automatic t_write();
        step(1'b1, 8'h50, 7'h7a, 7'h01, 7'h00);
        step(1'b1, 8'h48, 7'h7a, 7'h02, 7'h00);
        chk_char(7'h00, 8'h50);
        chk_char(7'h01, 8'h48);
    endtask

    task automatic t_line2();
        step(1'b0, 8'hc0, 7'h7a, 7'h40, 7'h00);
        step(1'b1, 8'h4d, 7'h7a, 7'h41, 7'h00);
        chk_char(7'h40, 8'h4d);
    endtask

    task automatic t_shift_write();
        step(1'b0, 8'h07, 7'h7b, 7'h41, 7'h00);
        step(1'b1, 8'h4f, 7'h7b, 7'h42, 7'h01);
    endtask

    // correction: cursor back, overwrite, then move forward again
    task automatic t_cursor();
        step(1'b0, 8'h10, 7'h7b, 7'h41, 7'h01);
        step(1'b0, 8'h10, 7'h7b, 7'h40, 7'h01);
        step(1'b1, 8'h43, 7'h7b, 7'h41, 7'h02);
        chk_char(7'h40, 8'h43);
        step(1'b0, 8'h1c, 7'h7b, 7'h42, 7'h01);
        step(1'b0, 8'h14, 7'h7b, 7'h43, 7'h01);
    endtask

    task automatic t_home();
        step(1'b0, 8'h02, 7'h7b, 7'h00, 7'h00);
    endtask

    // glyph target: data bypasses display memory, cursor and shift
    task automatic t_glyph();
        step(1'b0, 8'h45, 7'h7b, 7'h00, 7'h00);
        chk_glyph(1'b1, 6'h05, 1'b0, 8'h00);
        step(1'b1, 8'h1f, 7'h7b, 7'h00, 7'h00);
        chk_glyph(1'b1, 6'h06, 1'b1, 8'h1f);
        step(1'b0, 8'h01, 7'h7b, 7'h00, 7'h00);
        chk_glyph(1'b1, 6'h06, 1'b0, 8'h1f);
        chk_char(7'h00, 8'h50);
    endtask

    // mid-run reset: writes go back to display memory
    task automatic t_after_reset();
        chk_glyph(1'b0, 6'h00, 1'b0, 8'h00);
        step(1'b1, 8'h41, 7'h42, 7'h01, 7'h00);
        chk_char(7'h00, 8'h41);
    endtask

    initial begin
        reset_n = 1'b0;
        clkEn = 1'b1;
        scanAddr = 7'h00;
        fails = 0;
        checked = 0;
        do_reset();
        t_setup();
        t_write();
        t_line2();
        t_shift_write();
        t_cursor();
        t_home();
        t_glyph();
        do_reset();
        t_after_reset();
        test_done();
    end

    // watchdog: the tests need well under 2000 cycles
    initial begin
        #1000000;
        fails++;
        test_done();
    end
endmodule
